// ==== io_wdt_pkg.sv ====
`default_nettype none
package io_wdt_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int STRB_W = 4;
  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRQ_EN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_LOAD = 8'h10;
  localparam logic [7:0] ADDR_WDATA = 8'h14;
  localparam logic [7:0] ADDR_KICK = 8'h18;
  localparam logic [7:0] ADDR_OUT = 8'h1C;
  localparam logic [7:0] ADDR_IN = 8'h20;
  localparam logic [7:0] ADDR_COUNT = 8'h24;
  localparam logic [7:0] ADDR_PIN = 8'h28;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_WDOG_EN_BIT = 0;
  localparam int SRQ_WDOG_BIT = 1;
  localparam int STATUS_WDOG_BIT = 0;
  localparam logic [31:0] LOAD_RESET = 32'h0000_0001;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] WORD_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] COUNT_MAX = 32'hFFFF_FFFF;
  localparam logic [3:0] STRB_ALL = 4'hF;
  // ****************************************************************
  // Timing: counter rate derived from the bus clock
  // ****************************************************************
  localparam int CLK_FREQ_MHZ = 100;
  localparam int WDT_FREQ_MHZ = 12;
  localparam real WDT_PERIOD_NS = 83.333;
  localparam int ACC_W = 7;
  localparam logic [6:0] ACC_INC = 7'(WDT_FREQ_MHZ);
  localparam logic [6:0] ACC_WRAP = 7'(CLK_FREQ_MHZ - WDT_FREQ_MHZ);
  localparam logic [6:0] ACC_LIMIT = 7'(CLK_FREQ_MHZ - WDT_FREQ_MHZ);
  // ****************************************************************
  // Bus responses and states
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN = 2'b01,
    WD_EXPIRED = 2'b10
  } wd_state_t;
endpackage
`default_nettype wire

// ==== wdt_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_gen (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  import io_wdt_pkg::*;
  // ****************************************************************
  // Fractional divider: 12 ticks per 100 clocks, jitter one clock
  // ****************************************************************
  logic [ACC_W-1:0] acc;
  wire wrap = (acc >= ACC_LIMIT);
  wire [ACC_W-1:0] next_acc = wrap ? (acc - ACC_WRAP) : (acc + ACC_INC);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= '0;
      tick <= 1'b0;
    end else begin
      acc <= next_acc;
      tick <= wrap;
    end
  end
endmodule // wdt_tick_gen
`default_nettype wire

// ==== axil_reg_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module axil_reg_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [io_wdt_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [io_wdt_pkg::DATA_W-1:0] wdata,
  input wire logic [io_wdt_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [io_wdt_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [io_wdt_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_fire,
  output logic [io_wdt_pkg::ADDR_W-1:0] wr_addr,
  output logic [io_wdt_pkg::DATA_W-1:0] wr_data,
  output logic [io_wdt_pkg::STRB_W-1:0] wr_strb,
  input wire logic wr_ok,
  output logic [io_wdt_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [io_wdt_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_ok
);
  import io_wdt_pkg::*;
  // ****************************************************************
  // Write channels held independently, fired once both are in
  // ****************************************************************
  logic aw_held;
  logic w_held;
  assign awready = !aw_held;
  assign wready = !w_held;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign rd_addr = araddr;
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // Read: data captured at the address handshake
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // axil_reg_port
`default_nettype wire

// ==== io_watchdog_timer.sv ====
// How it works
// - Input at or below low threshold reads zero
// - Input high or open reads one
// - Output bit one turns sink driver on
// - Output bit zero leaves terminal floating
// - Counter steps once per 12 MHz tick
// - Expiry copies watchdog pattern to outputs
// - Expiry sets status bit 0 flag
// - Watchdog runs only while enable bit set
// - Service request on expiry when bit 1 set
// - Expiry after two-to-32 minus load ticks
// - Load value zero is not accepted
// - Kick restarts count from programmed value
`timescale 1ns/1ps
`default_nettype none
module io_watchdog_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [io_wdt_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [io_wdt_pkg::DATA_W-1:0] wdata,
  input wire logic [io_wdt_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [io_wdt_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [io_wdt_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [io_wdt_pkg::DATA_W-1:0] in_term,
  input wire logic [io_wdt_pkg::DATA_W-1:0] out_pin_i,
  output logic [io_wdt_pkg::DATA_W-1:0] out_pin_o,
  output logic [io_wdt_pkg::DATA_W-1:0] out_pin_oe,
  output logic irq,
  output logic srq
);
  import io_wdt_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [DATA_W-1:0] merge_strb(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Bus slave and tick source
  // ****************************************************************
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  logic tick;

  axil_reg_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_fire(wr_fire),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  wdt_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  logic wd_enable;
  logic srq_wdog_en;
  logic wd_flag;
  logic wd_mask;
  logic [DATA_W-1:0] load_val;
  logic [DATA_W-1:0] wdt_data;
  logic [DATA_W-1:0] out_reg;
  logic [DATA_W-1:0] in_data;
  logic [DATA_W-1:0] pin_state;
  logic [DATA_W-1:0] count;
  wd_state_t state;
  wd_state_t next_state;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  wire wr_ctrl = wr_fire && (wr_addr == ADDR_CTRL);
  wire wr_srq = wr_fire && (wr_addr == ADDR_SRQ_EN);
  wire wr_status = wr_fire && (wr_addr == ADDR_STATUS);
  wire wr_mask = wr_fire && (wr_addr == ADDR_MASK);
  wire wr_load = wr_fire && (wr_addr == ADDR_LOAD);
  wire wr_wdata = wr_fire && (wr_addr == ADDR_WDATA);
  wire kick = wr_fire && (wr_addr == ADDR_KICK);
  wire wr_out = wr_fire && (wr_addr == ADDR_OUT);
  wire wr_ro = (wr_addr == ADDR_IN) || (wr_addr == ADDR_COUNT) || (wr_addr == ADDR_PIN);
  assign wr_ok = (wr_ctrl || wr_srq || wr_status || wr_mask || wr_load || wr_wdata || kick || wr_out)
                 || wr_ro;

  wire [DATA_W-1:0] load_merged = merge_strb(load_val, wr_data, wr_strb);
  wire load_accept = wr_load && (load_merged != WORD_ZERO);
  wire status_clr = wr_status && wr_strb[0] && wr_data[STATUS_WDOG_BIT];

  // ****************************************************************
  // Watchdog sequencing
  // ****************************************************************
  // Disabling drops straight to idle, so a stale count never expires later
  wire start_load = wd_enable && ((state == WD_IDLE) || kick);
  wire at_max = (count == COUNT_MAX);
  wire expire = (state == WD_RUN) && wd_enable && tick && at_max && !kick;

  always_comb begin
    next_state = state;
    case (state)
      WD_IDLE: begin
        if (wd_enable) begin
          next_state = WD_RUN;
        end
      end
      WD_RUN: begin
        if (!wd_enable) begin
          next_state = WD_IDLE;
        end else if (expire) begin
          next_state = WD_EXPIRED;
        end
      end
      WD_EXPIRED: begin
        if (!wd_enable) begin
          next_state = WD_IDLE;
        end else if (kick) begin
          next_state = WD_RUN;
        end
      end
      default: begin
        next_state = WD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= WD_IDLE;
      count <= WORD_ZERO;
    end else begin
      state <= next_state;
      if (start_load) begin
        count <= load_val;
      end else if ((state == WD_RUN) && tick) begin
        count <= count + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_enable <= 1'b0;
      srq_wdog_en <= 1'b0;
      wd_mask <= 1'b0;
      load_val <= LOAD_RESET;
      wdt_data <= WORD_ZERO;
    end else begin
      if (wr_ctrl && wr_strb[0]) begin
        wd_enable <= wr_data[CTRL_WDOG_EN_BIT];
      end
      if (wr_srq && wr_strb[0]) begin
        srq_wdog_en <= wr_data[SRQ_WDOG_BIT];
      end
      if (wr_mask && wr_strb[0]) begin
        wd_mask <= wr_data[STATUS_WDOG_BIT];
      end
      if (load_accept) begin
        load_val <= load_merged;
      end
      if (wr_wdata) begin
        wdt_data <= merge_strb(wdt_data, wr_data, wr_strb);
      end
    end
  end

  // Expiry outranks a same-cycle software write to the outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= WORD_ZERO;
      wd_flag <= 1'b0;
      srq <= 1'b0;
    end else begin
      if (expire) begin
        out_reg <= wdt_data;
      end else if (wr_out) begin
        out_reg <= merge_strb(out_reg, wr_data, wr_strb);
      end
      wd_flag <= expire || (wd_flag && !status_clr);
      srq <= expire && srq_wdog_en;
    end
  end

  // ****************************************************************
  // Pins
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_data <= WORD_ONES;
      pin_state <= WORD_ONES;
    end else begin
      in_data <= in_term;
      pin_state <= out_pin_i;
    end
  end

  // Open drain: only ever pull low, a one in out_reg enables the sink
  assign out_pin_o = WORD_ZERO;
  assign out_pin_oe = out_reg;
  assign irq = wd_flag && wd_mask;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire [DATA_W-1:0] ctrl_word = {31'h0, wd_enable};
  wire [DATA_W-1:0] srq_word = {30'h0, srq_wdog_en, 1'b0};
  wire [DATA_W-1:0] status_word = {31'h0, wd_flag};
  wire [DATA_W-1:0] mask_word = {31'h0, wd_mask};
  assign rd_ok = (rd_addr == ADDR_CTRL) || (rd_addr == ADDR_SRQ_EN) || (rd_addr == ADDR_STATUS)
                 || (rd_addr == ADDR_MASK) || (rd_addr == ADDR_LOAD) || (rd_addr == ADDR_WDATA)
                 || (rd_addr == ADDR_KICK) || (rd_addr == ADDR_OUT) || (rd_addr == ADDR_IN)
                 || (rd_addr == ADDR_COUNT) || (rd_addr == ADDR_PIN);
  assign rd_data = (rd_addr == ADDR_CTRL) ? ctrl_word :
                   (rd_addr == ADDR_SRQ_EN) ? srq_word :
                   (rd_addr == ADDR_STATUS) ? status_word :
                   (rd_addr == ADDR_MASK) ? mask_word :
                   (rd_addr == ADDR_LOAD) ? load_val :
                   (rd_addr == ADDR_WDATA) ? wdt_data :
                   (rd_addr == ADDR_OUT) ? out_reg :
                   (rd_addr == ADDR_IN) ? in_data :
                   (rd_addr == ADDR_COUNT) ? count :
                   (rd_addr == ADDR_PIN) ? pin_state : WORD_ZERO;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_IN_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((in_data & ~$past(in_term)) == WORD_ZERO))
    else $error("input low did not read zero");

  AST_IN_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((~in_data & $past(in_term)) == WORD_ZERO))
    else $error("input high or open did not read one");

  AST_OUT_ON: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_out && (wr_strb == STRB_ALL) && !expire)
      |=> ((out_pin_oe & $past(wr_data)) == $past(wr_data)) && (out_pin_o == WORD_ZERO))
    else $error("written one did not enable sink");

  AST_OUT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_out && (wr_strb == STRB_ALL) && !expire) |=> ((out_pin_oe & ~$past(wr_data)) == WORD_ZERO))
    else $error("written zero left sink enabled");

  AST_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
    ((state == WD_RUN) && !start_load && !expire)
      |=> (count == ($past(count) + ($past(tick) ? 32'h0000_0001 : WORD_ZERO))))
    else $error("counter did not step with tick");

  AST_EXPIRE_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    expire |=> (out_pin_oe == $past(wdt_data)) && (state == WD_EXPIRED))
    else $error("pattern not applied on expiry");

  AST_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    expire |=> wd_flag ##1 (wd_flag || $past(status_clr)))
    else $error("status flag not held after expiry");

  AST_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    !wd_enable |=> (state == WD_IDLE) && !srq && !$rose(wd_flag))
    else $error("watchdog active while disabled");

  AST_SRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    srq |-> $past(expire) && $past(srq_wdog_en) && wd_flag)
    else $error("service request without enabled expiry");

  AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == WD_EXPIRED) |-> ($past(count) == COUNT_MAX) && $past(tick))
    else $error("expiry not at counter overflow");

  AST_LOAD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (load_val != WORD_ZERO))
    else $error("zero timeout accepted");

  AST_KICK: assert property (@(posedge aclk) disable iff (!aresetn)
    (kick && wd_enable && (state != WD_IDLE)) |=> (state == WD_RUN) && (count == $past(load_val)))
    else $error("kick did not restart count");

  AST_START: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wd_enable) && (state == WD_IDLE) |=> (state == WD_RUN) && (count == $past(load_val)))
    else $error("enable did not load the count");

  COV_EXPIRE: cover property (@(posedge aclk) disable iff (!aresetn) expire);
  COV_KICK_RUN: cover property (@(posedge aclk) disable iff (!aresetn) kick && (state == WD_RUN));
  COV_SRQ: cover property (@(posedge aclk) disable iff (!aresetn) srq);
  COV_SET_CLR: cover property (@(posedge aclk) disable iff (!aresetn) expire && status_clr);
endmodule // io_watchdog_timer
`default_nettype wire

// ==== io_term_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module io_term_model (
  input wire logic [io_wdt_pkg::DATA_W-1:0] sink_en,
  input wire logic [io_wdt_pkg::DATA_W-1:0] drive_val,
  output logic [io_wdt_pkg::DATA_W-1:0] level
);
  import io_wdt_pkg::*;
  // ****************************************************************
  // Terminal load
  // ****************************************************************
  // Pull-up on each terminal, so a released line reads high, never stale
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      level[i] = sink_en[i] ? drive_val[i] : 1'b1;
    end
  end
endmodule // io_term_model
`default_nettype wire

// ==== test_io_watchdog_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_io_watchdog_timer;
  import io_wdt_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, srq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, in_term, rdata, pin_i, pin_o, pin_oe, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] loads [3] = '{32'hFFFF_FFFF, 32'hFFFF_FFF8, 32'hFFFF_FFF0};
  int n_errors = 0;
  int compares = 0;
  int n_srq = 0;
  int n;
  int ticks;
  logic [3:0] strb_sel = STRB_ALL;

  io_watchdog_timer DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .in_term(in_term),
    .out_pin_i(pin_i), .out_pin_o(pin_o), .out_pin_oe(pin_oe), .irq(irq), .srq(srq));
  io_term_model term (.sink_en(pin_oe), .drive_val(pin_o), .level(pin_i));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (srq === 1'b1) n_srq <= n_srq + 1;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stall(input string what);
    n_errors++;
    $display("mismatch %s expected handshake seen timeout", what);
    end_sim();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
    int k;
    logic done;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb_sel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        done = 1'b1;
        rsp = bresp;
        bready <= 1'b0;
      end
      if (++k > 50) stall("write");
    end
    chk("bresp", {30'h0, exp_resp}, {30'h0, rsp});
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    int k;
    logic done;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        done = 1'b1;
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
      end
      if (++k > 50) stall("read");
    end
    chk(what, exp, rd);
    chk("rresp", {30'h0, exp_resp}, {30'h0, rsp});
  endtask

  task automatic wait_irq(output int cyc);
    cyc = 0;
    while (irq !== 1'b1) begin
      @(posedge aclk);
      cyc++;
      if (cyc > 400) stall("irq");
    end
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    in_term = 32'hFFFF_FFFF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("load reset", ADDR_LOAD, LOAD_RESET, RESP_OKAY);
    rd_chk("wdata reset", ADDR_WDATA, WORD_ZERO, RESP_OKAY);
    rd_chk("out reset", ADDR_OUT, WORD_ZERO, RESP_OKAY);
    rd_chk("unmapped read", 8'h40, WORD_ZERO, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    $display("test reset and bus done");
    // Terminal polarity on both sides
    in_term <= 32'h0F0F_A5A5;
    wr(ADDR_OUT, 32'hC300_00FF, RESP_OKAY);
    chk("sink enable", 32'hC300_00FF, pin_oe);
    rd_chk("pin readback", ADDR_PIN, 32'h3CFF_FF00, RESP_OKAY);
    rd_chk("input sample", ADDR_IN, 32'h0F0F_A5A5, RESP_OKAY);
    $display("test terminals done");
    // Expiry at several loads; shortest is the one-tick boundary, the last runs without service request
    wr(ADDR_WDATA, 32'h5A3C_0F81, RESP_OKAY);
    wr(ADDR_MASK, 32'h1, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      wr(ADDR_STATUS, 32'h1, RESP_OKAY);
      wr(ADDR_SRQ_EN, (i < 2) ? 32'h2 : 32'h0, RESP_OKAY);
      wr(ADDR_OUT, 32'hC300_00FF, RESP_OKAY);
      wr(ADDR_LOAD, loads[i], RESP_OKAY);
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      ticks = int'(~loads[i]) + 1;
      wait_irq(n);
      chk("expiry time", 32'h1, 32'(n >= ticks * 100 / 12 - 10 && n <= ticks * 100 / 12 + 12));
      chk("expiry pattern", 32'h5A3C_0F81, pin_oe);
      rd_chk("status flag", ADDR_STATUS, 32'h1, RESP_OKAY);
      chk("srq count", 32'((i < 2) ? i + 1 : 2), 32'(n_srq));
    end
    // Byte strobes: only the two low lanes of the pattern change
    strb_sel = 4'h3;
    wr(ADDR_WDATA, 32'hFFFF_FFFF, RESP_OKAY);
    strb_sel = STRB_ALL;
    rd_chk("wdata strobe", ADDR_WDATA, 32'h5A3C_FFFF, RESP_OKAY);
    $display("test expiry done");
    // Interrupt mask and write-one clear
    wr(ADDR_MASK, 32'h0, RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADDR_MASK, 32'h1, RESP_OKAY);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(ADDR_STATUS, 32'h1, RESP_OKAY);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    // Kicks well inside the 16-tick timeout keep the pattern away
    wr(ADDR_LOAD, 32'hFFFF_FFF0, RESP_OKAY);
    wr(ADDR_KICK, 32'h0, RESP_OKAY);
    wr(ADDR_OUT, 32'h0000_0033, RESP_OKAY);
    repeat (4) begin
      repeat (90) @(posedge aclk);
      wr(ADDR_KICK, 32'h0, RESP_OKAY);
    end
    rd_chk("no expiry", ADDR_STATUS, 32'h0, RESP_OKAY);
    chk("outputs kept", 32'h0000_0033, pin_oe);
    wr(ADDR_LOAD, 32'h0, RESP_OKAY);
    rd_chk("load zero refused", ADDR_LOAD, 32'hFFFF_FFF0, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    repeat (200) @(posedge aclk);
    rd_chk("disabled quiet", ADDR_STATUS, 32'h0, RESP_OKAY);
    chk("srq quiet", 32'h2, 32'(n_srq));
    $display("test kick and disable done");
    end_sim();
  end
endmodule // test_io_watchdog_timer
`default_nettype wire
